// ==== hdl/ievs_params.svh ====
`ifndef IEVS_PARAMS_SVH
`define IEVS_PARAMS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define IEVS_W 16
`define IEVS_DIGITS 5
`define IEVS_BCD_W 20

// ****************************************************************
// Reset values and fixed patterns
// ****************************************************************
`define IEVS_ZERO 16'h0000
`define IEVS_RESERVED 16'hC020
`define IEVS_BIT_ONE 16'h0001

// ****************************************************************
// Event bit positions in the internal event latch
// ****************************************************************
`define IEVS_B_TRIG 13
`define IEVS_B_PASS 12
`define IEVS_B_TRACE_A 8
`define IEVS_B_SWAP 7
`define IEVS_B_FULL 6
`define IEVS_B_SEGMENT 4
`define IEVS_B_TIMEOUT 3
`define IEVS_B_LOCAL 2
`define IEVS_B_DUMP 1
`define IEVS_B_ACQ 0

`endif

// ==== hdl/ievs_pkg.sv ====
`include "ievs_params.svh"

package ievs_pkg;

    // ****************************************************************
    // Host command codes
    // ****************************************************************
    typedef enum logic [1:0] {
        IEVS_CMD_NONE = 2'b00, // No command this cycle
        IEVS_CMD_MASK_WR = 2'b01, // Load the enable mask
        IEVS_CMD_MASK_RD = 2'b10, // Query the enable mask
        IEVS_CMD_LATCH_RD = 2'b11 // Query and clear the event latch
    } ievs_cmd_e;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    // One host command with its value
    typedef struct packed {
        ievs_cmd_e code;
        logic [`IEVS_W-1:0] data;
    } ievs_cmd_s;

    // Event sources from the instrument's own logic
    typedef struct packed {
        logic trig_ready; // Level: trigger armed and ready
        logic pass_hit; // Pulse: pass/fail outcome reached
        logic [3:0] trace_done; // Pulses: trace D, C, B, A finished
        logic medium_swap; // Pulse: storage medium exchanged
        logic medium_full; // Level: storage medium full
        logic save_until_medium_full; // Level: store-until-full mode on
        logic segment_done; // Pulse: one sequence segment taken
        logic xfer_timeout; // Pulse: block transfer timed out
        logic remote_mode; // Level: under remote control
        logic dump_done; // Pulse: screen dump finished
        logic acq_done; // Pulse: new acquisition complete
    } ievs_events_s;

    // One answer to a query
    typedef struct packed {
        logic valid;
        ievs_cmd_e kind;
        logic [`IEVS_W-1:0] value;
        logic [`IEVS_BCD_W-1:0] bcd;
    } ievs_resp_s;

endpackage

// ==== hdl/ievs_edge.sv ====
`timescale 1ns/1ns

// ****************************************************************
// Edge detector for a same-clock level
// ****************************************************************
module ievs_edge #(
    parameter bit RISING = 1'b1
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic level_in,
    output logic pulse_out
);
    logic prev_q; // Level seen on the last edge

    // Remember the level; reset to low
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            prev_q <= 1'b0;
        else
            prev_q <= level_in;
    end

    // One-cycle pulse on the chosen edge
    assign pulse_out = RISING ? (level_in & ~prev_q) : (~level_in & prev_q);

endmodule // ievs_edge

// ==== hdl/ievs_sticky.sv ====
`timescale 1ns/1ns

// ****************************************************************
// One sticky event bit, set over clear
// ****************************************************************
module ievs_sticky (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic set_in,
    input wire logic clr_in,
    output logic q_out
);
    logic bit_q; // Stored event
    logic bit_d; // Next value

    // A set in the clearing cycle survives
    assign bit_d = set_in | (bit_q & ~clr_in);

    // Store; reset to clear
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            bit_q <= 1'b0;
        else
            bit_q <= bit_d;
    end

    assign q_out = bit_q;

endmodule // ievs_sticky

// ==== hdl/ievs_top.sv ====
`timescale 1ns/1ns
`include "ievs_params.svh"

// Operation
// - 16-bit enable mask written and read back
// - Summary bit when enabled event is set
// - Latch query returns contents then clears
// - Bits 15 and 14 read zero
// - Bit 5 reads zero
// - Bit 13 trigger ready, 12 pass/fail
// - Bits 11..8 trace D..A processing done
// - Bit 7 on storage medium exchange
// - Bit 6 medium full in store-until-full mode
// - Bit 4 per sequence segment acquired
// - Bit 3 on block transfer time-out
// - Bit 2 on return to local
// - Bit 1 when screen dump finishes
// - Bit 0 on each new acquisition
// - Latch reported as one decimal value
module ievs_top (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire ievs_pkg::ievs_cmd_s cmd_in,
    input wire ievs_pkg::ievs_events_s events_in,
    output ievs_pkg::ievs_resp_s resp_out,
    output logic event_summary_bit_out
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [`IEVS_W-1:0] event_enable_mask_q; // Enable mask
    logic [`IEVS_W-1:0] event_enable_mask_d; // Its next value
    logic [`IEVS_W-1:0] internal_event_latch; // Sticky events
    logic [`IEVS_W-1:0] set_vec; // Events arriving now
    logic [`IEVS_W-1:0] enabled_events; // Events passing the mask
    ievs_pkg::ievs_resp_s resp_q; // Registered answer
    ievs_pkg::ievs_resp_s resp_d; // Next answer
    logic [`IEVS_W-1:0] resp_value; // Value chosen for the answer
    logic is_mask_wr; // Mask load decoded
    logic is_mask_rd; // Mask query decoded
    logic is_latch_rd; // Latch query decoded
    logic is_query; // Any query
    logic trig_pulse; // Trigger became ready
    logic full_pulse; // Medium became full
    logic full_event; // Full while store-until-full on
    logic local_pulse; // Remote control dropped

    // ****************************************************************
    // Decimal conversion
    // ****************************************************************
    // Shift-and-add-three binary to five decimal digits
    function automatic logic [`IEVS_BCD_W-1:0] to_bcd(input logic [`IEVS_W-1:0] bin);
        logic [`IEVS_BCD_W+`IEVS_W-1:0] sh;
        sh = {{`IEVS_BCD_W{1'b0}}, bin};
        for (int i = 0; i < `IEVS_W; i++)
        begin
            for (int k = 0; k < `IEVS_DIGITS; k++)
            begin
                // Digit above four gets three added before the shift
                if (sh[`IEVS_W + 4*k +: 4] > 4'h4)
                    sh[`IEVS_W + 4*k +: 4] = sh[`IEVS_W + 4*k +: 4] + 4'h3;
            end
            sh = sh << 1;
        end
        return sh[`IEVS_BCD_W+`IEVS_W-1:`IEVS_W];
    endfunction

    // ****************************************************************
    // Command decode
    // ****************************************************************
    assign is_mask_wr = (cmd_in.code == ievs_pkg::IEVS_CMD_MASK_WR);
    assign is_mask_rd = (cmd_in.code == ievs_pkg::IEVS_CMD_MASK_RD);
    assign is_latch_rd = (cmd_in.code == ievs_pkg::IEVS_CMD_LATCH_RD);
    assign is_query = is_mask_rd | is_latch_rd;

    // ****************************************************************
    // Level events turned into one-cycle pulses
    // ****************************************************************
    // Trigger ready on its rising edge
    ievs_edge #(
        .RISING(1'b1)
    ) u_trig_edge (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .level_in(events_in.trig_ready),
        .pulse_out(trig_pulse)
    );

    // Medium full on its rising edge
    ievs_edge #(
        .RISING(1'b1)
    ) u_full_edge (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .level_in(events_in.medium_full),
        .pulse_out(full_pulse)
    );

    // Return to local on the falling edge of remote mode
    ievs_edge #(
        .RISING(1'b0)
    ) u_local_edge (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .level_in(events_in.remote_mode),
        .pulse_out(local_pulse)
    );

    // Full counts only while store-until-full mode is on
    assign full_event = full_pulse & events_in.save_until_medium_full;

    // ****************************************************************
    // Event set vector
    // ****************************************************************
    // Reserved positions never see a set
    always_comb
    begin
        set_vec = `IEVS_ZERO;
        set_vec[`IEVS_B_TRIG] = trig_pulse;
        set_vec[`IEVS_B_PASS] = events_in.pass_hit;
        set_vec[`IEVS_B_TRACE_A +: 4] = events_in.trace_done;
        set_vec[`IEVS_B_SWAP] = events_in.medium_swap;
        set_vec[`IEVS_B_FULL] = full_event;
        set_vec[`IEVS_B_SEGMENT] = events_in.segment_done;
        set_vec[`IEVS_B_TIMEOUT] = events_in.xfer_timeout;
        set_vec[`IEVS_B_LOCAL] = local_pulse;
        set_vec[`IEVS_B_DUMP] = events_in.dump_done;
        set_vec[`IEVS_B_ACQ] = events_in.acq_done;
    end

    // ****************************************************************
    // Internal event latch
    // ****************************************************************
    // Sticky cells on implemented bits, zero on reserved ones
    for (genvar i = 0; i < `IEVS_W; i++)
    begin : g_latch
        if (((`IEVS_RESERVED >> i) & `IEVS_BIT_ONE) != `IEVS_ZERO)
        begin : g_reserved
            assign internal_event_latch[i] = 1'b0;
        end
        else
        begin : g_event
            // Set over clear; cleared by a latch query
            ievs_sticky u_bit (
                .mclk_in(mclk_in),
                .rst_in(rst_in),
                .set_in(set_vec[i]),
                .clr_in(is_latch_rd),
                .q_out(internal_event_latch[i])
            );
        end
    end

    // ****************************************************************
    // Enable mask
    // ****************************************************************
    // Full 16-bit value loaded as given
    assign event_enable_mask_d = is_mask_wr ? cmd_in.data : event_enable_mask_q;

    // Mask storage; cleared by reset
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            event_enable_mask_q <= `IEVS_ZERO;
        else
            event_enable_mask_q <= event_enable_mask_d;
    end

    // ****************************************************************
    // Summary bit
    // ****************************************************************
    assign enabled_events = internal_event_latch & event_enable_mask_q;
    assign event_summary_bit_out = |enabled_events;

    // ****************************************************************
    // Query answers
    // ****************************************************************
    // Latch contents before the clear, or the mask as stored
    assign resp_value = is_latch_rd ? internal_event_latch : event_enable_mask_q;
    assign resp_d.valid = is_query;
    assign resp_d.kind = cmd_in.code;
    assign resp_d.value = resp_value;
    assign resp_d.bcd = to_bcd(resp_value);

    // Answer register; one cycle after the query
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            resp_q <= '0;
        else
            resp_q <= resp_d;
    end

    assign resp_out = resp_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [16:0] bcd_back; // Decimal answer turned back to binary

    // Weighted sum of the answer digits
    assign bcd_back = 17'(resp_q.bcd[19:16]) * 17'h02710
        + 17'(resp_q.bcd[15:12]) * 17'h003E8
        + 17'(resp_q.bcd[11:8]) * 17'h00064
        + 17'(resp_q.bcd[7:4]) * 17'h0000A
        + 17'(resp_q.bcd[3:0]);

    // Trigger goes ready over two cycles
    sequence s_trig_rise;
        !events_in.trig_ready ##1 events_in.trig_ready;
    endsequence

    // Remote control drops over two cycles
    sequence s_remote_drop;
        events_in.remote_mode ##1 !events_in.remote_mode;
    endsequence

    // Mask load then query returns the same value
    property p_mask_rw;
        @(posedge mclk_in) disable iff (rst_in)
        (is_mask_wr ##1 is_mask_rd) |=> (resp_q.valid && resp_q.value == $past(cmd_in.data, 2));
    endproperty
    a_mask_rw: assert property (p_mask_rw) else $error("mask readback wrong");

    // Enabled event raises the summary bit next cycle
    property p_summary;
        @(posedge mclk_in) disable iff (rst_in)
        (|(set_vec & event_enable_mask_q) && !is_mask_wr) |=> event_summary_bit_out;
    endproperty
    a_summary: assert property (p_summary) else $error("summary bit missing");

    // Summary drops once a quiet latch query empties the latch
    property p_summary_low;
        @(posedge mclk_in) disable iff (rst_in)
        (is_latch_rd && set_vec == `IEVS_ZERO) |=> !event_summary_bit_out;
    endproperty
    a_summary_low: assert property (p_summary_low) else $error("summary bit stray");

    // Query returns contents, then latch is empty
    property p_read_clear;
        @(posedge mclk_in) disable iff (rst_in)
        (is_latch_rd && set_vec == `IEVS_ZERO)
            |=> (internal_event_latch == `IEVS_ZERO && resp_q.valid
            && resp_q.value == $past(internal_event_latch));
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read and clear wrong");

    // Reserved bits never show in a latch answer
    property p_reserved;
        @(posedge mclk_in) disable iff (rst_in)
        (resp_q.valid && resp_q.kind == ievs_pkg::IEVS_CMD_LATCH_RD)
            |-> ((resp_q.value & `IEVS_RESERVED) == `IEVS_ZERO);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    // Trigger ready sets bit 13
    property p_trig;
        @(posedge mclk_in) disable iff (rst_in)
        s_trig_rise |=> internal_event_latch[`IEVS_B_TRIG];
    endproperty
    a_trig: assert property (p_trig) else $error("trigger event missed");

    // Trace D done sets bit 11
    property p_trace_d;
        @(posedge mclk_in) disable iff (rst_in)
        events_in.trace_done[3] |=> internal_event_latch[`IEVS_B_TRACE_A + 3];
    endproperty
    a_trace_d: assert property (p_trace_d) else $error("trace D event missed");

    // Full without store-until-full mode leaves bit 6 alone
    property p_full_mode;
        @(posedge mclk_in) disable iff (rst_in)
        (!events_in.save_until_medium_full && !internal_event_latch[`IEVS_B_FULL])
            |=> !internal_event_latch[`IEVS_B_FULL];
    endproperty
    a_full_mode: assert property (p_full_mode) else $error("full event without mode");

    // Return to local sets bit 2
    property p_local;
        @(posedge mclk_in) disable iff (rst_in)
        s_remote_drop |=> internal_event_latch[`IEVS_B_LOCAL];
    endproperty
    a_local: assert property (p_local) else $error("local return missed");

    // Decimal digits match the binary answer
    property p_decimal;
        @(posedge mclk_in) disable iff (rst_in)
        resp_q.valid |-> (bcd_back == {1'b0, resp_q.value});
    endproperty
    a_decimal: assert property (p_decimal) else $error("decimal answer wrong");

    // Set bit holds while no query clears it
    property p_sticky;
        @(posedge mclk_in) disable iff (rst_in)
        (internal_event_latch[`IEVS_B_ACQ] && !is_latch_rd) |=> internal_event_latch[`IEVS_B_ACQ];
    endproperty
    a_sticky: assert property (p_sticky) else $error("event bit lost");

    // Event in the clearing cycle survives
    property p_set_wins;
        @(posedge mclk_in) disable iff (rst_in)
        (is_latch_rd && events_in.acq_done) |=> internal_event_latch[`IEVS_B_ACQ];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost at clear");

    // Pass/fail outcome sets bit 12
    property p_pass;
        @(posedge mclk_in) disable iff (rst_in)
        events_in.pass_hit |=> internal_event_latch[`IEVS_B_PASS];
    endproperty
    a_pass: assert property (p_pass) else $error("pass event missed");

    // Medium exchange sets bit 7
    property p_swap;
        @(posedge mclk_in) disable iff (rst_in)
        events_in.medium_swap |=> internal_event_latch[`IEVS_B_SWAP];
    endproperty
    a_swap: assert property (p_swap) else $error("medium exchange missed");

    // Sequence segment sets bit 4
    property p_segment;
        @(posedge mclk_in) disable iff (rst_in)
        events_in.segment_done |=> internal_event_latch[`IEVS_B_SEGMENT];
    endproperty
    a_segment: assert property (p_segment) else $error("segment event missed");

    // Transfer time-out sets bit 3
    property p_timeout;
        @(posedge mclk_in) disable iff (rst_in)
        events_in.xfer_timeout |=> internal_event_latch[`IEVS_B_TIMEOUT];
    endproperty
    a_timeout: assert property (p_timeout) else $error("time-out event missed");

    // Screen dump end sets bit 1
    property p_dump;
        @(posedge mclk_in) disable iff (rst_in)
        events_in.dump_done |=> internal_event_latch[`IEVS_B_DUMP];
    endproperty
    a_dump: assert property (p_dump) else $error("dump event missed");

    // New acquisition sets bit 0
    property p_acq;
        @(posedge mclk_in) disable iff (rst_in)
        events_in.acq_done |=> internal_event_latch[`IEVS_B_ACQ];
    endproperty
    a_acq: assert property (p_acq) else $error("acquisition event missed");

    // Reset empties both registers and the answer
    property p_reset_clear;
        @(posedge mclk_in)
        rst_in |=> (event_enable_mask_q == `IEVS_ZERO && internal_event_latch == `IEVS_ZERO
            && !resp_q.valid);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset left state");

endmodule // ievs_top

// ==== dv/ievs_host.sv ====
`timescale 1ns/1ns

// ****************************************************************
// Host controller model: one command at a time
// ****************************************************************
module ievs_host (
    input wire logic mclk_in,
    input wire ievs_pkg::ievs_resp_s resp_in,
    output ievs_pkg::ievs_cmd_s cmd_out
);
    // Idle bus at time zero
    initial
    begin
        cmd_out = '0;
    end

    // Load the mask; callers pass any 16-bit value, reserved bits included
    task automatic write_mask(input logic [15:0] v);
    begin
        @(posedge mclk_in);
        #1;
        cmd_out.code = ievs_pkg::IEVS_CMD_MASK_WR;
        cmd_out.data = v;
        @(posedge mclk_in);
        #1;
        cmd_out.code = ievs_pkg::IEVS_CMD_NONE;
        cmd_out.data = ~v; // Stale data inverted once released
    end
    endtask

    // Load the mask and query it in the very next cycle
    task automatic write_query(input logic [15:0] v, output ievs_pkg::ievs_resp_s r);
    begin
        @(posedge mclk_in);
        #1;
        cmd_out.code = ievs_pkg::IEVS_CMD_MASK_WR;
        cmd_out.data = v;
        @(posedge mclk_in);
        #1;
        cmd_out.code = ievs_pkg::IEVS_CMD_MASK_RD;
        @(posedge mclk_in);
        #1;
        r = resp_in;
        cmd_out.code = ievs_pkg::IEVS_CMD_NONE;
    end
    endtask

    // Issue a query, take the answer one edge later
    task automatic query(input ievs_pkg::ievs_cmd_e c, output ievs_pkg::ievs_resp_s r);
    begin
        @(posedge mclk_in);
        #1;
        cmd_out.code = c;
        cmd_out.data = ~cmd_out.data; // Data is a don't-care here
        @(posedge mclk_in);
        #1;
        r = resp_in;
        cmd_out.code = ievs_pkg::IEVS_CMD_NONE;
    end
    endtask
endmodule // ievs_host

// ==== dv/test_ievs_top.sv ====
`timescale 1ns/1ns

// ****************************************************************
// Self-checking bench for the event status unit
// ****************************************************************
module test_ievs_top;
    typedef struct {
        logic [13:0] pre; // Event inputs one cycle before
        logic [13:0] act; // Event inputs in the firing cycle
        logic [15:0] exp; // Latch contents expected
    } ievs_row_s;

    logic mclk_in; // System clock
    logic rst_in; // Synchronous reset
    ievs_pkg::ievs_cmd_s cmd; // Host command
    ievs_pkg::ievs_events_s ev; // Event sources
    ievs_pkg::ievs_resp_s resp; // Query answer
    logic summary; // Summary bit
    ievs_pkg::ievs_resp_s r; // Last answer taken
    ievs_row_s rows [15]; // Event table
    logic [15:0] mvals [3]; // Mask values
    int error_cnt;
    int total_checks;

    // ****************************************************************
    // Instances
    // ****************************************************************
    ievs_top uut (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .cmd_in(cmd),
        .events_in(ev),
        .resp_out(resp),
        .event_summary_bit_out(summary)
    );

    ievs_host host (
        .mclk_in(mclk_in),
        .resp_in(resp),
        .cmd_out(cmd)
    );

    // Clock, 40 ns period
    initial
    begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Decimal digits of a value
    function automatic logic [19:0] to_bcd(input logic [15:0] v);
        logic [19:0] b;
        int n;
        b = '0;
        n = v;
        for (int i = 0; i < 5; i++)
        begin
            b[i*4+:4] = 4'(n % 10);
            n = n / 10;
        end
        return b;
    endfunction

    // Compare and count
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    begin
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    end
    endtask

    // Query and compare the whole answer
    task automatic exp_resp(input ievs_pkg::ievs_cmd_e c, input logic [15:0] v);
    begin
        host.query(c, r);
        check({r.valid, r.kind, r.value, r.bcd}, {1'b1, c, v, to_bcd(v)});
    end
    endtask

    // One-cycle event pulse
    task automatic pulse(input logic [13:0] v);
    begin
        @(posedge mclk_in);
        #1;
        ev = v;
        @(posedge mclk_in);
        #1;
        ev = '0;
    end
    endtask

    // Verdict and end of run
    task automatic end_sim;
    begin
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge mclk_in);
        error_cnt++;
        $display("mismatch at %0t: run too long", $time);
        end_sim();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        rst_in = 1'b1;
        ev = '0;
        error_cnt = 0;
        total_checks = 0;
        mvals = '{16'h0000, 16'hFFFF, 16'hA5C3};
        rows = '{
            '{14'h0000, 14'h2000, 16'h2000},
            '{14'h0000, 14'h1000, 16'h1000},
            '{14'h0000, 14'h0800, 16'h0800},
            '{14'h0000, 14'h0400, 16'h0400},
            '{14'h0000, 14'h0200, 16'h0200},
            '{14'h0000, 14'h0100, 16'h0100},
            '{14'h0000, 14'h0080, 16'h0080},
            '{14'h0020, 14'h0060, 16'h0040},
            '{14'h0000, 14'h0040, 16'h0000},
            '{14'h0000, 14'h0010, 16'h0010},
            '{14'h0000, 14'h0008, 16'h0008},
            '{14'h0004, 14'h0000, 16'h0004},
            '{14'h0000, 14'h0002, 16'h0002},
            '{14'h0000, 14'h0001, 16'h0001},
            '{14'h0024, 14'h3FFB, 16'h3FDF}
        };
        repeat (5) @(posedge mclk_in);
        #1;
        rst_in = 1'b0;
        check(summary, 1'b0);
        exp_resp(ievs_pkg::IEVS_CMD_MASK_RD, 16'h0000);
        exp_resp(ievs_pkg::IEVS_CMD_LATCH_RD, 16'h0000);
        $display("reset state test done");
        // Table of event sources
        foreach (rows[i])
        begin
            host.write_mask(rows[i].exp | 16'h0040);
            @(posedge mclk_in);
            #1;
            ev = rows[i].pre;
            pulse(rows[i].act);
            check(summary, rows[i].exp != 16'h0000);
            exp_resp(ievs_pkg::IEVS_CMD_LATCH_RD, rows[i].exp);
            check(summary, 1'b0);
        end
        $display("event table done");
        // Mask write and read back at the range ends and one mixed pattern, each also inverted
        foreach (mvals[i])
        begin
            host.write_mask(mvals[i]);
            exp_resp(ievs_pkg::IEVS_CMD_MASK_RD, mvals[i]);
            host.write_query(~mvals[i], r);
            check({r.valid, r.kind, r.value}, {1'b1, ievs_pkg::IEVS_CMD_MASK_RD, ~mvals[i]});
        end
        $display("mask test done");
        // Masked event stays out of summary but stays latched
        host.write_mask(16'h0002 + 16'h0001);
        pulse(14'h0010);
        repeat (3) @(posedge mclk_in);
        #1;
        check(summary, 1'b0);
        pulse(14'h0002);
        check(summary, 1'b1);
        host.write_mask(16'h0000);
        check(summary, 1'b0);
        exp_resp(ievs_pkg::IEVS_CMD_LATCH_RD, 16'h0012);
        $display("summary test done");
        // Event arriving in the clearing cycle survives
        pulse(14'h0002);
        fork
            host.query(ievs_pkg::IEVS_CMD_LATCH_RD, r);
            pulse(14'h0001);
        join
        check({r.valid, r.value}, {1'b1, 16'h0002});
        exp_resp(ievs_pkg::IEVS_CMD_LATCH_RD, 16'h0001);
        $display("clear race test done");
        // Reset in mid-run clears both registers
        host.write_mask(16'hFFFF);
        pulse(14'h0001);
        check(summary, 1'b1);
        @(posedge mclk_in);
        #1;
        rst_in = 1'b1;
        @(posedge mclk_in);
        #1;
        check({resp.valid, summary}, 2'b00);
        rst_in = 1'b0;
        exp_resp(ievs_pkg::IEVS_CMD_MASK_RD, 16'h0000);
        exp_resp(ievs_pkg::IEVS_CMD_LATCH_RD, 16'h0000);
        $display("reset test done");
        end_sim();
    end
endmodule // test_ievs_top
